// [psp_slave_port.v]
// parallel slave byte port with its registers
// ----------------------------------------------------------------
// Summary of operation
// - select bit makes data port a slave
// - host strobes sampled, no host clock
// - select bit turns pins into strobes
// - firmware sets pins input and digital
// - separate output and input byte latches
// - direction register ignored in slave mode
// - select and write low start write
// - write end sets input full, event
// - only latch read or leaving mode clears input full
// - write while full sets overrun flag
// - select and read low clear output full
// - read end sets event flag
// - output full stays clear until written
// - outside mode full flags held clear
// - event flag sticky, mask gates request
// - strobes and select are active low
// ----------------------------------------------------------------
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "psp_consts.vh"
module psp_slave_port (
    // clock and reset
    input  wire       ref_clk,
    input  wire       sys_rst,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // data pins
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output wire [7:0] data_oe,
    // control pins
    input  wire [2:0] strobe_in,
    output reg  [2:0] strobe_out,
    output wire [2:0] strobe_oe,
    // received byte stream
    output wire       rx_valid,
    input  wire       rx_ready,
    output wire [7:0] rx_data,
    // interrupt request
    output wire       port_event_irq
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    reg [2:0]  strobe_s1;
    reg [2:0]  strobe_s2;
    reg [7:0]  data_s1;
    reg [7:0]  data_s2;
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0]  out_latch;
    reg [7:0]  in_latch;
    reg [7:0]  byte_port_direction;
    reg [2:0]  strobe_dir;
    reg [2:0]  strobe_latch;
    reg [2:0]  analog_config_field;
    reg        slave_port_select;
    reg        input_full_flag;
    reg        output_full_flag;
    reg        input_overrun_flag;
    reg [7:0]  peripheral_flags_one;
    reg [7:0]  peripheral_masks_one;
    reg [`PSP_PHASE_W-1:0] phase;
    reg        wr_active;
    reg        rd_active;
    reg        wr_pend;
    reg        rd_pend;
    reg        wr_seen_q2;
    reg        rd_seen_q2;
    reg        next_input_full;
    reg        next_output_full;
    reg        next_overrun;
    reg        next_event;
    reg [7:0]  next_rdata;
    wire       rd_n;
    wire       wr_n;
    wire       cs_n;
    wire       host_wr;
    wire       host_rd;
    wire       wr_done;
    wire       rd_done;
    wire       at_q2;
    wire       at_q4;
    wire       pins_digital;
    wire       fifo_in_ready;
    wire       sw_wr_latch;
    wire       sw_rd_latch;
    wire       sw_wr_stat;
    wire       sw_wr_flags;

    always @(posedge ref_clk) begin
        strobe_s1 <= strobe_in;
        strobe_s2 <= strobe_s1;
        data_s1   <= data_in;
        data_s2   <= data_s1;
    end

    assign pins_digital = (analog_config_field == `PSP_ANALOG_DIGITAL_ALL) & (&strobe_dir);
    assign rd_n = strobe_s2[0];
    assign wr_n = strobe_s2[1];
    assign cs_n = strobe_s2[2];
    assign host_wr = slave_port_select & pins_digital & !cs_n & !wr_n;
    assign host_rd = slave_port_select & pins_digital & !cs_n & !rd_n;
    assign wr_done = wr_active & !host_wr;
    assign rd_done = rd_active & !host_rd;

    // ------------------------------------------------------------
    // internal phase clock
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= {`PSP_PHASE_W{1'b0}};
        end else begin
            phase <= phase + 1'b1;
        end
    end
    assign at_q2 = (phase == `PSP_PHASE_TWO);
    assign at_q4 = (phase == `PSP_PHASE_FOUR);

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // drive during host read
    assign data_oe   = host_rd ? 8'hff :
                       (slave_port_select ? 8'h00 : ~byte_port_direction);
    assign strobe_oe = slave_port_select ? 3'h0 : ~strobe_dir;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            data_out   <= `PSP_RST_BYTE;
            strobe_out <= 3'h0;
        end else begin
            data_out   <= out_latch;
            strobe_out <= strobe_latch;
        end
    end

    // ------------------------------------------------------------
    // software access decode
    // ------------------------------------------------------------
    assign sw_wr_latch = reg_wr & (reg_addr == `PSP_ADDR_BYTE_PORT_LATCH);
    assign sw_rd_latch = reg_rd & (reg_addr == `PSP_ADDR_BYTE_PORT_LATCH);
    assign sw_wr_stat  = reg_wr & (reg_addr == `PSP_ADDR_STROBE_DIR_STAT);
    assign sw_wr_flags = reg_wr & (reg_addr == `PSP_ADDR_FLAGS_ONE);

    // ------------------------------------------------------------
    // flag updates
    // ------------------------------------------------------------
    always @* begin
        next_input_full  = input_full_flag;
        next_output_full = output_full_flag;
        next_overrun     = input_overrun_flag;
        next_event       = peripheral_flags_one[`PSP_BIT_PORT_EVENT];
        if (sw_rd_latch) begin
            next_input_full = 1'b0;
        end
        if (sw_wr_stat && !reg_wdata[`PSP_BIT_INPUT_OVERRUN]) begin
            next_overrun = 1'b0;
        end
        if (sw_wr_flags && !reg_wdata[`PSP_BIT_PORT_EVENT]) begin
            next_event = 1'b0;
        end
        if (sw_wr_latch) begin
            next_output_full = 1'b1;
        end
        if (host_rd) begin
            next_output_full = 1'b0;
        end
        if (wr_pend && wr_seen_q2 && at_q4) begin
            if (input_full_flag && !sw_rd_latch) begin
                next_overrun = 1'b1;
            end
            next_input_full = 1'b1;
            next_event      = 1'b1;
        end
        if (rd_pend && rd_seen_q2 && at_q4) begin
            next_event = 1'b1;
        end
        // full flags cleared out of mode
        if (!slave_port_select) begin
            next_input_full  = 1'b0;
            next_output_full = 1'b0;
        end
    end

    assign port_event_irq = peripheral_flags_one[`PSP_BIT_PORT_EVENT]
                          & peripheral_masks_one[`PSP_BIT_PORT_EVENT];

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            out_latch            <= `PSP_RST_BYTE;
            in_latch             <= `PSP_RST_BYTE;
            byte_port_direction  <= `PSP_RST_BYTE_DIR;
            strobe_dir           <= `PSP_RST_STROBE_DIR;
            strobe_latch         <= 3'h0;
            analog_config_field  <= `PSP_RST_ANALOG_CFG;
            slave_port_select    <= 1'b0;
            input_full_flag      <= 1'b0;
            output_full_flag     <= 1'b0;
            input_overrun_flag   <= 1'b0;
            peripheral_flags_one <= `PSP_RST_FLAGS_ONE;
            peripheral_masks_one <= `PSP_RST_MASKS_ONE;
            wr_active            <= 1'b0;
            rd_active            <= 1'b0;
            wr_pend              <= 1'b0;
            rd_pend              <= 1'b0;
            wr_seen_q2           <= 1'b0;
            rd_seen_q2           <= 1'b0;
        end else begin
            input_full_flag    <= next_input_full;
            output_full_flag   <= next_output_full;
            input_overrun_flag <= next_overrun;
            peripheral_flags_one[`PSP_BIT_PORT_EVENT] <= next_event;
            wr_active <= host_wr;
            rd_active <= host_rd;
            if (host_wr) begin
                in_latch <= data_s2;
            end
            if (wr_done) begin
                wr_pend    <= 1'b1;
                wr_seen_q2 <= 1'b0;
            end else if (wr_pend && at_q2) begin
                wr_seen_q2 <= 1'b1;
            end else if (wr_pend && wr_seen_q2 && at_q4) begin
                wr_pend    <= 1'b0;
                wr_seen_q2 <= 1'b0;
            end
            if (rd_done) begin
                rd_pend    <= 1'b1;
                rd_seen_q2 <= 1'b0;
            end else if (rd_pend && at_q2) begin
                rd_seen_q2 <= 1'b1;
            end else if (rd_pend && rd_seen_q2 && at_q4) begin
                rd_pend    <= 1'b0;
                rd_seen_q2 <= 1'b0;
            end
            if (sw_wr_latch) begin
                out_latch <= reg_wdata;
            end
            if (reg_wr && reg_addr == `PSP_ADDR_STROBE_PIN_PORT) begin
                strobe_latch <= reg_wdata[2:0];
            end
            if (sw_wr_stat) begin
                slave_port_select <= reg_wdata[`PSP_BIT_SLAVE_SELECT];
                strobe_dir        <= reg_wdata[2:0];
            end
            if (sw_wr_flags) begin
                peripheral_flags_one[6:0] <= reg_wdata[6:0];
            end
            if (reg_wr && reg_addr == `PSP_ADDR_MASKS_ONE) begin
                peripheral_masks_one <= reg_wdata;
            end
            if (reg_wr && reg_addr == `PSP_ADDR_ANALOG_PIN_CFG) begin
                analog_config_field <= reg_wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @* begin
        if (reg_addr == `PSP_ADDR_BYTE_PORT_LATCH) begin
            next_rdata = slave_port_select ? in_latch : data_s2;
        end else if (reg_addr == `PSP_ADDR_STROBE_PIN_PORT) begin
            next_rdata = {5'h00, (pins_digital ? strobe_s2 : 3'h0)};
        end else if (reg_addr == `PSP_ADDR_FLAGS_ONE) begin
            next_rdata = peripheral_flags_one;
        end else if (reg_addr == `PSP_ADDR_STROBE_DIR_STAT) begin
            next_rdata = {input_full_flag, output_full_flag, input_overrun_flag,
                          slave_port_select, 1'b0, strobe_dir};
        end else if (reg_addr == `PSP_ADDR_MASKS_ONE) begin
            next_rdata = peripheral_masks_one;
        end else if (reg_addr == `PSP_ADDR_ANALOG_PIN_CFG) begin
            next_rdata = {5'h00, analog_config_field};
        end else begin
            next_rdata = 8'h00;
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // received byte fifo
    // ------------------------------------------------------------
    psp_fifo #(
        .WIDTH (8),
        .DEPTH (`PSP_FIFO_DEPTH),
        .AW    (`PSP_FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_done),
        .in_ready  (fifo_in_ready),
        .in_data   (in_latch),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );
endmodule // psp_slave_port

// [psp_consts.vh]
// constants for the parallel slave byte port
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PSP_ADDR_BYTE_PORT_LATCH   8'h08
`define PSP_ADDR_STROBE_PIN_PORT   8'h09
`define PSP_ADDR_FLAGS_ONE         8'h0c
`define PSP_ADDR_STROBE_DIR_STAT   8'h89
`define PSP_ADDR_MASKS_ONE         8'h8c
`define PSP_ADDR_ANALOG_PIN_CFG    8'h9f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSP_RST_STROBE_DIR         3'h7
`define PSP_RST_FLAGS_ONE          8'h00
`define PSP_RST_MASKS_ONE          8'h00
`define PSP_RST_ANALOG_CFG         3'h0
`define PSP_RST_BYTE               8'h00
`define PSP_RST_BYTE_DIR           8'hff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSP_BIT_INPUT_FULL         7
`define PSP_BIT_OUTPUT_FULL        6
`define PSP_BIT_INPUT_OVERRUN      5
`define PSP_BIT_SLAVE_SELECT       4
`define PSP_BIT_PORT_EVENT         7
`define PSP_ANALOG_DIGITAL_ALL     3'h7

// ----------------------------------------------------------------
// phase clock and fifo
// ----------------------------------------------------------------
`define PSP_PHASE_W                2
`define PSP_PHASE_TWO              2'h1
`define PSP_PHASE_FOUR             2'h3
`define PSP_FIFO_DEPTH             16
`define PSP_FIFO_AW                4

`endif

// [psp_fifo.v]
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module psp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             sys_rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // psp_fifo

// [psp_checker_checker.sv]
// assertions on the ports of the parallel slave byte port
`timescale 1ns/1ps
module psp_checker (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and request
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic [2:0] strobe_in,
    input wire logic [2:0] strobe_oe,
    input wire logic       port_event_irq
);
    logic       mode_q;
    logic       mask_q;
    logic [2:0] dir_q;
    logic [2:0] cfg_q;
    logic [7:0] out_q;
    wire        mode_ok = mode_q && dir_q == 3'h7 && cfg_q == 3'h7;
    wire        unmapped = !(reg_addr inside {8'h08, 8'h09, 8'h0c, 8'h89, 8'h8c, 8'h9f});

    // ----------------------------------------------------------------
    // shadow of the control registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_q <= 1'b0;
            mask_q <= 1'b0;
            dir_q  <= 3'h7;
            cfg_q  <= 3'h0;
            out_q  <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h89) begin
                mode_q <= reg_wdata[4];
                dir_q  <= reg_wdata[2:0];
            end
            if (reg_addr == 8'h8c)
                mask_q <= reg_wdata[7];
            if (reg_addr == 8'h9f)
                cfg_q <= reg_wdata[2:0];
            if (reg_addr == 8'h08)
                out_q <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // host transfers
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence host_write_end;
        (!strobe_in[1] && !strobe_in[2]) [*2] ##1 strobe_in[1];
    endsequence
    sequence host_read_end;
        (!strobe_in[0] && !strobe_in[2]) [*2] ##1 strobe_in[0];
    endsequence

    a_write_event: assert property ((mask_q && mode_ok) ##0 host_write_end |->
        ##[1:12] port_event_irq) else $error("no event after host write");
    a_read_event: assert property ((mask_q && mode_ok) ##0 host_read_end |->
        ##[1:12] port_event_irq) else $error("no event after host read");
    a_irq_masked: assert property (!mask_q |-> !port_event_irq)
        else $error("request raised while masked");
    a_event_sticky: assert property ($fell(port_event_irq) |-> $past(reg_wr) &&
        ($past(reg_addr) == 8'h0c || $past(reg_addr) == 8'h8c))
        else $error("event request dropped by itself");
    a_oe_on_read: assert property (mode_q == $past(mode_q, 3) |-> data_oe ==
        ((mode_ok && !$past(strobe_in[0], 2) && !$past(strobe_in[2], 2)) ? 8'hff : 8'h00))
        else $error("data pin enable wrong");
    a_pins_carry_latch: assert property (mode_q && data_oe == 8'hff |-> data_out == $past(out_q))
        else $error("driven byte is not the output latch");
    a_strobe_pins_in: assert property (strobe_oe == (mode_q ? 3'h0 : ~dir_q))
        else $error("control pin enable wrong");
    a_rdata_quiet: assert property (!$past(reg_rd) || $past(unmapped) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_status_fields: assert property ($past(reg_rd) && $past(reg_addr) == 8'h89 |->
        reg_rdata[4:0] == {$past(mode_q), 1'b0, $past(dir_q)})
        else $error("status register low fields wrong");
endmodule // psp_checker

bind psp_slave_port psp_checker chk (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .data_out       (data_out),
    .data_oe        (data_oe),
    .strobe_in      (strobe_in),
    .strobe_oe      (strobe_oe),
    .port_event_irq (port_event_irq)
);

// [psp_host_model.sv]
// external host that strobes bytes into and out of the port
`timescale 1ns/1ps
module psp_host_model (
    // clock
    input  wire logic       ref_clk,
    // data pins
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    output wire logic [7:0] data_in,
    // control pins
    output logic      [2:0] strobe_in
);
    logic       drv_en = 1'b0;
    logic [7:0] drv_val = 8'h00;
    logic [7:0] last_val = 8'h00;
    initial strobe_in = 3'h7;

    // released bus shows the inverse of its last level
    assign data_in = (data_oe & data_out) | (~data_oe & (drv_en ? drv_val : ~last_val));
    always @(posedge ref_clk) begin
        if (drv_en)
            last_val <= drv_val;
        else if (data_oe == 8'hff)
            last_val <= data_out;
    end

    task automatic host_write(input logic [7:0] v, input int hold);
        @(posedge ref_clk);
        strobe_in <= 3'h1;
        drv_en    <= 1'b1;
        drv_val   <= v;
        repeat (hold) @(posedge ref_clk);
        strobe_in <= 3'h7;
        repeat (3) @(posedge ref_clk);
        drv_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic host_read(output logic [7:0] v, input int hold);
        @(posedge ref_clk);
        strobe_in <= 3'h2;
        repeat (hold) @(posedge ref_clk);
        v = data_in;
        strobe_in <= 3'h7;
        repeat (12) @(posedge ref_clk);
    endtask
endmodule // psp_host_model

// [parallel_slave_byte_port_test.sv]
// self-checking bench for the parallel slave byte port
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module parallel_slave_byte_port_test;
    logic       ref_clk;
    logic       sys_rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, data_in, data_out, data_oe, rx_data, b, x, e;
    logic       reg_wr, reg_rd, rd_d, rx_ready, rx_valid, port_event_irq;
    logic [2:0] strobe_in, strobe_out, strobe_oe;
    logic [7:0] rdq[$];
    logic [7:0] rxq[$];
    int         mismatches, checks, n;

    psp_slave_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .strobe_in(strobe_in),
        .strobe_out(strobe_out), .strobe_oe(strobe_oe), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .port_event_irq(port_event_irq));
    psp_host_model host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .strobe_in(strobe_in));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // register bus and host tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rdq.push_back(exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic hw(input logic [7:0] v);
        if (n < 16)
            rxq.push_back(v);
        n++;
        host.host_write(v, $urandom_range(2, 6));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // result watcher
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rd_d) begin
            e = rdq.pop_front();
            `CHK(reg_rdata, e)
        end
        rd_d <= reg_rd;
        if (rx_valid && rx_ready) begin
            `CHK(rxq.size() != 0, 1'b1)
            if (rxq.size() != 0) begin
                e = rxq.pop_front();
                `CHK(rx_data, e)
            end
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h4f962d6c));
        {sys_rst, reg_wr, reg_rd, rx_ready} = 4'b1000;
        {reg_addr, reg_wdata} = 16'h0000;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h0c, 8'h00);
        rd(8'h89, 8'h07);
        rd(8'h8c, 8'h00);
        rd(8'h9f, 8'h00);
        rd(8'h09, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        wr(8'h9f, 8'h07);
        wr(8'h8c, 8'h80);
        wr(8'h89, 8'h17);
        rd(8'h09, 8'h07);
        x = 8'($urandom);
        wr(8'h08, x);
        rd(8'h89, 8'h57);
        host.host_read(b, $urandom_range(4, 7));
        `CHK(b, x)
        rd(8'h89, 8'h17);
        rd(8'h0c, 8'h80);
        `CHK(port_event_irq, 1'b1)
        wr(8'h0c, 8'h00);
        rd(8'h0c, 8'h00);
        hw(8'($urandom));
        rd(8'h89, 8'h97);
        rd(8'h0c, 8'h80);
        x = 8'($urandom);
        hw(x);
        rd(8'h89, 8'hb7);
        rd(8'h08, x);
        rd(8'h89, 8'h37);
        wr(8'h89, 8'h17);
        rd(8'h89, 8'h17);
        wr(8'h8c, 8'h00);
        rd(8'h0c, 8'h80);
        `CHK(port_event_irq, 1'b0)
        repeat (15) hw(8'($urandom));
        `CHK(rx_valid, 1'b1)
        repeat (120) @(posedge ref_clk) rx_ready <= 1'($urandom);
        @(posedge ref_clk) rx_ready <= 1'b1;
        repeat (20) @(posedge ref_clk);
        `CHK(rxq.size(), 0)
        wr(8'h08, 8'h3c);
        rd(8'h89, 8'hf7);
        wr(8'h89, 8'h27);
        rd(8'h89, 8'h27);
        wr(8'h0c, 8'h00);
        host.host_write(8'h5a, 4);
        rd(8'h0c, 8'h00);
        `CHK(rx_valid, 1'b0)
        rd(8'h08, 8'ha5);
        wr(8'h89, 8'h07);
        rd(8'h89, 8'h07);
        wr(8'h89, 8'h02);
        rd(8'h89, 8'h02);
        x = 8'($urandom);
        wr(8'h09, x);
        repeat (2) @(posedge ref_clk);
        `CHK(strobe_out, x[2:0])
        repeat (4) @(posedge ref_clk);
        end_of_test();
    end
endmodule // parallel_slave_byte_port_test
